// >>> design/stm_timer.v
// standard 16-bit compare/pwm timer with an apb register slave
//
// The register addresses and register access over APB were decided locally.
`include "stm_timer_map.vh"
`default_nettype none

module stm_timer #(
   parameter integer ADDR_WIDTH = 12
) (
   // clock and reset
   input  wire                  clk,
   input  wire                  reset_n,
   // apb slave
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [ADDR_WIDTH-1:0] paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata,
   output reg                   pready,
   output reg                   pslverr,
   // clock sources, synchronous to clk
   input  wire                  highClkTick,
   input  wire                  subClkTick,
   input  wire                  extClkIn,
   // output pin
   output reg                   timerOut,
   output reg                   timerOutEn,
   // match flag levels
   output reg                   matchAFlagOut,
   output reg                   matchPFlagOut
);

   // software-visible control and compare registers
   reg  [7:0]  ctrl0_reg;
   reg  [7:0]  ctrl1_reg;
   reg  [15:0] cmpA_reg;
   reg  [7:0]  cmpP_reg;

   // counter and its next value
   reg  [15:0] count_reg;
   reg  [15:0] count_next;

   // sticky match flags, cleared by writing ones
   reg         flagA_reg;
   reg         flagP_reg;

   // edge history for the enable bit and the external clock pin
   reg         enPrev_reg;
   reg         extPrev_reg;

   // prescaler counters; the high-speed ones only move on highClkTick
   reg  [1:0]  sysDiv_reg;
   reg  [3:0]  hi16Div_reg;
   reg  [5:0]  hi64Div_reg;

   // pin level before the optional inversion
   reg         pinLevel_reg;
   reg         pinLevel_next;

   // combinational strobes of the current cycle
   reg         tick;
   reg         clrCount;
   reg         setA;
   reg         setP;


   // control fields
   wire [2:0]  clkSel      = ctrl0_reg[`STM_BIT_CKSEL_HI:`STM_BIT_CKSEL_LO];
   wire        enable      = ctrl0_reg[`STM_BIT_ENABLE];
   wire        pause       = ctrl0_reg[`STM_BIT_PAUSE];
   wire [1:0]  mode        = ctrl1_reg[`STM_BIT_MODE_HI:`STM_BIT_MODE_LO];
   wire [1:0]  pinFn       = ctrl1_reg[`STM_BIT_PFN_HI:`STM_BIT_PFN_LO];
   wire        outInit     = ctrl1_reg[`STM_BIT_OINIT];
   wire        outInvert   = ctrl1_reg[`STM_BIT_OINV];
   wire        swap        = ctrl1_reg[`STM_BIT_SWAP];
   wire        clrSel      = ctrl1_reg[`STM_BIT_CLRSEL];

   // enable edge: the first enabled cycle only zeroes the counter and loads the pin
   wire        enRise      = enable & ~enPrev_reg;
   // counting stops while paused or disabled, and the count is kept
   wire        running     = enable & ~pause & ~enRise;

   // apb strobes; a write acts at the access edge, read data is fetched in setup
   wire        busWrite    = psel & penable & pwrite;
   wire        busRead     = psel & ~penable & ~pwrite;
   // matches are taken on the counting step that reaches the value
   wire [15:0] countInc    = count_reg + 16'h0001;
   wire        matchA      = tick & (cmpA_reg != 16'h0000) & (countInc == cmpA_reg);
   wire        matchP      = tick & (cmpP_reg != 8'h00) & (countInc == {cmpP_reg, 8'h00});
   wire        overflow    = tick & (count_reg == 16'hFFFF);

   // pwm compares use the present count, one register stage ahead of the pin
   wire [16:0] pwmPeriod   = swap ? {1'b0, cmpA_reg} : periodOfP(cmpP_reg);
   wire [16:0] pwmDuty     = swap ? periodOfP(cmpP_reg) : {1'b0, cmpA_reg};
   wire        pwmActive   = ({1'b0, count_reg} < pwmDuty) | (pwmDuty >= pwmPeriod);

   // P compare value expressed in counter clocks, zero meaning a full wrap
   // seventeen bits so that the 65536-count wrap can be told apart from zero
   function [16:0] periodOfP;
      input [7:0] val;
      begin
         periodOfP = (val == 8'h00) ? 17'h10000 : {1'b0, val, 8'h00};
      end
   endfunction

   // word-aligned apb decode, shared by read and write paths
   // only the low twelve address bits take part, higher bits alias
   function hit;
      input [ADDR_WIDTH-1:0] addr;
      input [11:0]           ofs;
      begin
         hit = (addr[11:0] == ofs);
      end
   endfunction

   wire mapped = hit(paddr, `STM_OFS_CTRL0) | hit(paddr, `STM_OFS_CTRL1) | hit(paddr, `STM_OFS_CNT_LO)
               | hit(paddr, `STM_OFS_CNT_HI) | hit(paddr, `STM_OFS_CMPA_LO) | hit(paddr, `STM_OFS_CMPA_HI)
               | hit(paddr, `STM_OFS_CMPP) | hit(paddr, `STM_OFS_FLAGS);

   // write-one-to-clear strobes for the sticky flags
   wire clrFlagA = busWrite & hit(paddr, `STM_OFS_FLAGS) & pwdata[`STM_BIT_FLAG_A];
   wire clrFlagP = busWrite & hit(paddr, `STM_OFS_FLAGS) & pwdata[`STM_BIT_FLAG_P];

   // counter clock selection; sub ticks are used as they come, external edges are found from the sampled level
   // the /16 and /64 dividers share highClkTick, so they stay in step
   always @* begin
      case (clkSel)
         3'b000:  tick = (sysDiv_reg == 2'd3);
         3'b001:  tick = 1'b1;
         3'b010:  tick = highClkTick & (hi16Div_reg == 4'hF);
         3'b011:  tick = highClkTick & (hi64Div_reg == 6'h3F);
         3'b100:  tick = subClkTick;
         3'b101:  tick = subClkTick;
         3'b110:  tick = extClkIn & ~extPrev_reg;
         default: tick = ~extClkIn & extPrev_reg;
      endcase
      tick = tick & running;
   end

   // clear source and flag sources per mode
   always @* begin
      clrCount = 1'b0;
      setA     = 1'b0;
      setP     = 1'b0;
      if (mode == `STM_MODE_PWM) begin
         // clear-select plays no part here
         // a zero P value disables the P clear and the count wraps at its maximum
         clrCount = swap ? matchA : (cmpP_reg == 8'h00 ? 1'b0 : matchP);
         setA     = matchA;
         setP     = matchP;
      end else if (clrSel) begin
         clrCount = matchA;
         setA     = matchA;
      end else begin
         clrCount = matchP;
         setA     = matchA;
         setP     = matchP;
      end
   end

   // next counter value; a zero P value simply lets the count wrap
   // a clear takes the place of the compare value, so the period is the value in ticks
   // an enable rise wins over any tick of the same cycle
   always @* begin
      count_next = count_reg;
      if (enRise)
         count_next = 16'h0000;
      else if (tick) begin
         if (clrCount | overflow)
            count_next = 16'h0000;
         else
            count_next = countInc;
      end
   end

   // pin level: pwm waveform or compare action on A match only
   // a pin function equal to the initial level gives no visible change
   // pwm function 11 is the single pulse mode, not built here, so the pin holds
   always @* begin
      pinLevel_next = pinLevel_reg;
      if (enRise)
         pinLevel_next = outInit;
      else if (mode == `STM_MODE_CMP) begin
         if (setA) begin
            case (pinFn)
               2'b00:   pinLevel_next = pinLevel_reg;
               2'b01:   pinLevel_next = 1'b0;
               2'b10:   pinLevel_next = 1'b1;
               default: pinLevel_next = ~pinLevel_reg;
            endcase
         end
      end else if (mode == `STM_MODE_PWM) begin
         case (pinFn)
            2'b00:   pinLevel_next = ~outInit;
            2'b01:   pinLevel_next = outInit;
            2'b10:   pinLevel_next = outInit ? pwmActive : ~pwmActive;
            default: pinLevel_next = pinLevel_reg;
         endcase
      end
   end

   // clock prescalers and edge history
   // free-running so that a new clock select takes effect without a restart
   always @(posedge clk) begin
      if (!reset_n) begin
         sysDiv_reg  <= 2'd0;
         hi16Div_reg <= 4'h0;
         hi64Div_reg <= 6'h00;
         extPrev_reg <= 1'b0;
         enPrev_reg  <= 1'b0;
      end else begin
         sysDiv_reg  <= sysDiv_reg + 2'd1;
         if (highClkTick) begin
            hi16Div_reg <= hi16Div_reg + 4'h1;
            hi64Div_reg <= hi64Div_reg + 6'h01;
         end
         extPrev_reg <= extClkIn;
         enPrev_reg  <= enable;
      end
   end

   // counter, pin and sticky flags
   always @(posedge clk) begin
      if (!reset_n) begin
         count_reg    <= 16'h0000;
         pinLevel_reg <= 1'b0;
         flagA_reg    <= 1'b0;
         flagP_reg    <= 1'b0;
      end else begin
         count_reg    <= count_next;
         pinLevel_reg <= pinLevel_next;
         // a new match wins over a software clear in the same cycle
         if (setA)
            flagA_reg <= 1'b1;
         else if (clrFlagA)
            flagA_reg <= 1'b0;
         if (setP)
            flagP_reg <= 1'b1;
         else if (clrFlagP)
            flagP_reg <= 1'b0;
      end
   end

   // control and compare registers, written at the apb access edge
   // the low three bits of ctrl0 are unimplemented and read zero
   // compare values may change while running; a new value applies from the next tick
   always @(posedge clk) begin
      if (!reset_n) begin
         ctrl0_reg <= `STM_CTRL0_RST;
         ctrl1_reg <= `STM_CTRL1_RST;
         cmpA_reg  <= 16'h0000;
         cmpP_reg  <= 8'h00;
      end else if (busWrite) begin
         if (hit(paddr, `STM_OFS_CTRL0))
            ctrl0_reg <= {pwdata[7:3], 3'b000};
         if (hit(paddr, `STM_OFS_CTRL1))
            ctrl1_reg <= pwdata[7:0];
         if (hit(paddr, `STM_OFS_CMPA_LO))
            cmpA_reg[7:0] <= pwdata[7:0];
         if (hit(paddr, `STM_OFS_CMPA_HI))
            cmpA_reg[15:8] <= pwdata[7:0];
         if (hit(paddr, `STM_OFS_CMPP))
            cmpP_reg <= pwdata[7:0];
      end
   end

   // apb answer: read data latched in setup, ready in the access cycle
   // unmapped addresses answer with pslverr and read as zero
   // no wait states: every register is a flip-flop, so data is ready at once
   always @(posedge clk) begin
      if (!reset_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (busRead) begin
            if (hit(paddr, `STM_OFS_CTRL0))
               prdata <= {24'h000000, ctrl0_reg};
            else if (hit(paddr, `STM_OFS_CTRL1))
               prdata <= {24'h000000, ctrl1_reg};
            else if (hit(paddr, `STM_OFS_CNT_LO))
               prdata <= {24'h000000, count_reg[7:0]};
            else if (hit(paddr, `STM_OFS_CNT_HI))
               prdata <= {24'h000000, count_reg[15:8]};
            else if (hit(paddr, `STM_OFS_CMPA_LO))
               prdata <= {24'h000000, cmpA_reg[7:0]};
            else if (hit(paddr, `STM_OFS_CMPA_HI))
               prdata <= {24'h000000, cmpA_reg[15:8]};
            else if (hit(paddr, `STM_OFS_CMPP))
               prdata <= {24'h000000, cmpP_reg};
            else if (hit(paddr, `STM_OFS_FLAGS))
               prdata <= {30'h00000000, flagP_reg, flagA_reg};
            else
               prdata <= 32'h00000000;
         end
      end
   end

   // pin drive; timer/counter mode releases the pin for other use
   // flag outputs mirror the sticky flags, with this cycle's set and clear applied
   // capture mode 01 is not built here, so the pin is left undriven there too
   always @(posedge clk) begin
      if (!reset_n) begin
         timerOut      <= 1'b0;
         timerOutEn    <= 1'b0;
         matchAFlagOut <= 1'b0;
         matchPFlagOut <= 1'b0;
      end else begin
         timerOut      <= (mode == `STM_MODE_TMR) ? 1'b0 : (pinLevel_next ^ outInvert);
         timerOutEn    <= (mode == `STM_MODE_CMP) | (mode == `STM_MODE_PWM);
         matchAFlagOut <= setA | (flagA_reg & ~clrFlagA);
         matchPFlagOut <= setP | (flagP_reg & ~clrFlagP);
      end
   end

endmodule // stm_timer
`default_nettype wire

// >>> design/stm_timer_map.vh
// register offsets, field positions and reset values of the standard timer
`ifndef STM_TIMER_MAP_VH
`define STM_TIMER_MAP_VH
`define STM_OFS_CTRL0      12'h000
`define STM_OFS_CTRL1      12'h004
`define STM_OFS_CNT_LO     12'h008
`define STM_OFS_CNT_HI     12'h00C
`define STM_OFS_CMPA_LO    12'h010
`define STM_OFS_CMPA_HI    12'h014
`define STM_OFS_CMPP       12'h018
`define STM_OFS_FLAGS      12'h01C
`define STM_CTRL0_RST      8'h00
`define STM_CTRL1_RST      8'h00
`define STM_BIT_PAUSE      7
`define STM_BIT_CKSEL_HI   6
`define STM_BIT_CKSEL_LO   4
`define STM_BIT_ENABLE     3
`define STM_BIT_MODE_HI    7
`define STM_BIT_MODE_LO    6
`define STM_BIT_PFN_HI     5
`define STM_BIT_PFN_LO     4
`define STM_BIT_OINIT      3
`define STM_BIT_OINV       2
`define STM_BIT_SWAP       1
`define STM_BIT_CLRSEL     0
`define STM_BIT_FLAG_A     0
`define STM_BIT_FLAG_P     1
`define STM_MODE_CMP       2'b00
`define STM_MODE_PWM       2'b10
`define STM_MODE_TMR       2'b11
`define STM_SYS_DIV        4
`define STM_HI16_DIV       16
`define STM_HI64_DIV       64
`endif

// >>> testbench/stm_timer_properties.sv
// port-level assertion checker for the standard timer
`include "stm_timer_map.vh"
`default_nettype none
module stm_timer_properties #(
   parameter integer ADDR_WIDTH = 12
) (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  reset_n,
   // apb slave
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0]           pwdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // pin enable and flags
   input wire logic                  timerOutEn,
   input wire logic                  matchAFlagOut,
   input wire logic                  matchPFlagOut
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // a write completing at this edge, per target
   wire wrEnd = psel && penable && pready && pwrite;
   wire wrFlag = wrEnd && paddr == `STM_OFS_FLAGS;
   wire wrCtl1 = wrEnd && paddr == `STM_OFS_CTRL1;
   property p_zeroWait; psel && !penable |=> pready; endproperty
   a_zeroWait: assert property (p_zeroWait) else $error("pready late");
   property p_oneCycle; pready |=> !pready; endproperty
   a_oneCycle: assert property (p_oneCycle) else $error("pready stuck");
   property p_errReady; pslverr |-> pready; endproperty
   a_errReady: assert property (p_errReady) else $error("pslverr alone");
   property p_unmapped; psel && !penable && paddr >= 12'h020 |=> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("no pslverr");
   // flags only drop through a clearing write, set wins otherwise
   property p_keepA; matchAFlagOut && !(wrFlag && pwdata[0]) |=> matchAFlagOut; endproperty
   a_keepA: assert property (p_keepA) else $error("flag A lost");
   property p_keepP; matchPFlagOut && !(wrFlag && pwdata[1]) |=> matchPFlagOut; endproperty
   a_keepP: assert property (p_keepP) else $error("flag P lost");
   // pin enable follows the mode written, allowing the register stage
   property p_tmrOff; wrCtl1 && pwdata[7:6] == `STM_MODE_TMR |-> ##2 !timerOutEn; endproperty
   a_tmrOff: assert property (p_tmrOff) else $error("pin driven in timer mode");
   property p_cmpOn; wrCtl1 && pwdata[7:6] == `STM_MODE_CMP |-> ##2 timerOutEn; endproperty
   a_cmpOn: assert property (p_cmpOn) else $error("pin idle in compare mode");
   c_flagA: cover property ($rose(matchAFlagOut));
   c_flagP: cover property ($rose(matchPFlagOut));
   c_err: cover property (pslverr);
endmodule // stm_timer_properties
bind stm_timer stm_timer_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.clk(clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .timerOutEn(timerOutEn), .matchAFlagOut(matchAFlagOut), .matchPFlagOut(matchPFlagOut));
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the standard timer
`include "stm_timer_map.vh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, pinOut, pinEn, flagA, flagP;
   int error_cnt = 0, tests_run = 0;
   always #2.5 clk = ~clk;
   // only the system clock source is exercised, other ticks held idle
   stm_timer uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .highClkTick(1'b0), .subClkTick(1'b0), .extClkIn(1'b0), .timerOut(pinOut), .timerOutEn(pinEn),
      .matchAFlagOut(flagA), .matchPFlagOut(flagP));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      // look half a cycle ahead of the edge that samples pready
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 32'h1, 32'h0);
   endtask
   task automatic waitHi(ref logic s, input int lim);
      int n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk("event", 32'h1, s);
   endtask
   // stop, clear flags, set mode, then restart from zero on the system clock
   task automatic start(input logic [7:0] c1);
      apb(1, `STM_OFS_CTRL0, 8'h00);
      apb(1, `STM_OFS_FLAGS, 8'h03);
      apb(1, `STM_OFS_CTRL1, c1);
      apb(1, `STM_OFS_CTRL0, 8'h18);
   endtask
   task automatic regTest();
      apb(1, `STM_OFS_CNT_LO, 8'hFF);
      for (int i = 2; i < 7; i++) begin
         apb(0, 12'(i * 4), 8'h00);
         chk("resetVal", 32'h0, rd);
      end
      apb(1, `STM_OFS_CMPA_HI, 8'hA5);
      apb(1, `STM_OFS_CMPP, 8'h3C);
      apb(0, `STM_OFS_CMPA_HI, 8'h00);
      chk("cmpAHi", 32'hA5, rd);
      apb(0, `STM_OFS_CMPP, 8'h00);
      chk("cmpP", 32'h3C, rd);
      apb(0, 12'h020, 8'h00);
      chk("unmapped", 32'h1, err);
   endtask
   // every pin function once, clear on A with P left at zero
   task automatic cmpTest();
      logic [1:0] fn;
      apb(1, `STM_OFS_CMPA_LO, 8'h20);
      apb(1, `STM_OFS_CMPA_HI, 8'h00);
      apb(1, `STM_OFS_CMPP, 8'h00);
      for (int f = 0; f < 4; f++) begin
         fn = 2'(f);
         start({2'b00, fn, fn == 2'b01, 3'b001});
         repeat (2) @(posedge clk);
         chk("pinInit", {31'h0, fn == 2'b01}, pinOut);
         waitHi(flagA, 100);
         @(posedge clk);
         chk("pinMatch", {31'h0, fn[1]}, pinOut);
         chk("noFlagP", 32'h0, flagP);
      end
      apb(0, `STM_OFS_CNT_LO, 8'h00);
      chk("cntBelowA", 32'h1, rd < 32'h20);
   endtask
   task automatic perTest();
      start(8'hC1);
      waitHi(flagA, 100);
      chk("tmrPin", 32'h0, pinEn);
      apb(1, `STM_OFS_CMPA_LO, 8'h80);
      apb(1, `STM_OFS_CMPP, 8'h01);
      start(8'h00);
      waitHi(flagP, 600);
      chk("flagA", 32'h1, flagA);
      apb(0, `STM_OFS_CNT_HI, 8'h00);
      chk("clearByP", 32'h0, rd);
   endtask
   // active cycles counted over one whole period after settling
   task automatic pwm(input logic [7:0] c1, input logic [7:0] p, input logic [7:0] a, input int per, input int hi);
      int n = 0;
      apb(1, `STM_OFS_CMPA_LO, a);
      apb(1, `STM_OFS_CMPP, p);
      start(c1);
      repeat (300) @(posedge clk);
      repeat (per) begin
         @(negedge clk);
         n += (pinOut === 1'b1);
      end
      chk("pwmHigh", hi, n);
   endtask
   task automatic pwmTest();
      pwm(8'hA9, 8'h01, 8'h40, 256, 64);
      chk("pwmFlags", 32'h3, {flagP, flagA});
      pwm(8'hAA, 8'h00, 8'hC8, 200, 200);
      pwm(8'hAC, 8'h01, 8'h40, 256, 192);
      pwm(8'h98, 8'h01, 8'h40, 256, 256);
      pwm(8'h88, 8'h01, 8'h40, 256, 0);
   endtask
   task automatic holdTest(input logic [7:0] c0);
      logic [31:0] held;
      start(8'hC0);
      apb(1, `STM_OFS_CTRL0, c0);
      apb(0, `STM_OFS_CNT_LO, 8'h00);
      held = rd;
      repeat (20) @(posedge clk);
      apb(0, `STM_OFS_CNT_LO, 8'h00);
      chk("held", held, rd);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // watchdog far beyond the roughly 3500 cycles of the run
   initial begin
      #200000;
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      regTest();
      cmpTest();
      perTest();
      pwmTest();
      holdTest(8'h98);
      holdTest(8'h00);
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
